// ---- logic/tio_debounce.sv ----
// level filter: output follows input after it differs for limit+1 steps
`timescale 1ns/10ps
module tio_debounce (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic step,
  input wire logic [7:0] limit,
  input wire logic din,
  output logic level_o
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic level_reg;
  logic level_next;

  always_comb begin
    cnt_next = cnt_reg;
    level_next = level_reg;
    if (din == level_reg) begin
      cnt_next = 8'h00;
    end else if (step) begin
      if (cnt_reg == limit) begin
        level_next = din;
        cnt_next = 8'h00;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg <= 8'h00;
      level_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
endmodule : tio_debounce

// ---- logic/tio_params.svh ----
// constants for the trigger and i/o conditioning block
`ifndef TIO_PARAMS_SVH
`define TIO_PARAMS_SVH

`define TIO_CLK_NS 50
`define TIO_TICK_NS 1000
`define TIO_TICK_CYC ((`TIO_TICK_NS) / (`TIO_CLK_NS))
`define TIO_ENC_FILT_NS 100
`define TIO_ENC_CYC ((`TIO_ENC_FILT_NS + `TIO_CLK_NS - 1) / (`TIO_CLK_NS))
`define TIO_DBN_MIN 8'h01

`define TIO_OFF_CTRL 8'h00
`define TIO_OFF_DBN 8'h04
`define TIO_OFF_GPO 8'h08
`define TIO_OFF_STROBE 8'h0C
`define TIO_OFF_LEVEL 8'h10
`define TIO_OFF_ISTAT 8'h14
`define TIO_OFF_IMASK 8'h18

`define TIO_CTRL_POL 0
`define TIO_CTRL_EN 2
`define TIO_CTRL_TWO 4
`define TIO_CTRL_SOFT 8
`define TIO_DBN_T1 0
`define TIO_DBN_T2 8
`define TIO_STB_EN 0
`define TIO_STB_LVL 2
`define TIO_LVL_GIN 0
`define TIO_LVL_TRIG 4
`define TIO_LVL_ENC 6

`define TIO_POL_RST 2'h3
`define TIO_EN_RST 2'h0
`define TIO_DBN_RST 8'h00
`define TIO_GPO_RST 4'h0
`define TIO_STB_RST 2'h0
`define TIO_INT_RST 6'h00

`endif

// ---- logic/tio_pkg.sv ----
// types for the trigger and i/o conditioning block
package tio_pkg;
  typedef enum logic [0:0] {
    TIO_FR_IDLE = 1'b0,
    TIO_FR_OPEN = 1'b1
  } tio_frame_t;
  typedef logic [7:0] tio_dbn_t;
endpackage : tio_pkg

// ---- logic/tio_top.sv ----
// trigger, encoder and general i/o conditioning with register port
//
// Behaviour
// [R01] trigger debounce programmable per input, 1 to 255 microseconds
// [R02] trigger pulses shorter than the debounce time never reach acquisition
// [R03] debounce setting zero behaves as one microsecond
// [R04] trigger valid once active longer than debounce; reported at that moment
// [R05] software selects active high or active low per trigger input
// [R06] software trigger acts exactly like a validated external trigger; code only pulses acq_trig, no status bit or frame open
// [R07] two-pulse line-scan mode: second trigger input ends the frame
// [R08] encoder phases a and b offered as line trigger source
// [R09] encoder phases filtered for 100 ns, shorter glitches rejected
// [R10] each general input raises own interrupt; levels readable
// [R11] general outputs driven from software-written register bits
// [R12] strobe outputs stay high impedance until software enables them
// [R13] one microsecond tick from clock; debounce count restarts when inactive
`timescale 1ns/10ps
`include "tio_params.svh"
module tio_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [1:0] ext_trig_in,
  input wire logic enc_phase_a,
  input wire logic enc_phase_b,
  input wire logic [3:0] gen_in,
  output logic [3:0] gen_out,
  output logic [1:0] strobe_out,
  output logic [1:0] strobe_oe,
  output logic acq_trig,
  output logic frame_end,
  output logic line_phase_a,
  output logic line_phase_b,
  output logic irq
);
  // microsecond tick
  logic [4:0] tick_cnt_reg;
  logic [4:0] tick_cnt_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    if (tick_cnt_reg == 5'(`TIO_TICK_CYC - 1)) begin // see [R13]
      tick_cnt_next = 5'h00;
      tick_next = 1'b1;
    end else begin
      tick_cnt_next = tick_cnt_reg + 5'h01;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_cnt_reg <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // software registers
  logic [1:0] pol_reg;
  logic [1:0] pol_next;
  logic [1:0] ten_reg;
  logic [1:0] ten_next;
  logic two_reg;
  logic two_next;
  logic soft_reg;
  logic soft_next;
  tio_pkg::tio_dbn_t dbn_reg [2];
  tio_pkg::tio_dbn_t dbn_next [2];
  logic [3:0] gpo_reg;
  logic [3:0] gpo_next;
  logic [1:0] stb_en_reg;
  logic [1:0] stb_en_next;
  logic [1:0] stb_lvl_reg;
  logic [1:0] stb_lvl_next;
  logic [5:0] istat_reg;
  logic [5:0] istat_next;
  logic [5:0] imask_reg;
  logic [5:0] imask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  logic irq_next;

  // filtered inputs
  logic [1:0] trig_act;
  logic [1:0] trig_lvl;
  logic [1:0] trig_prev_reg;
  logic [1:0] trig_rise;
  logic [1:0] enc_raw;
  logic [1:0] enc_lvl;
  logic [1:0] enc_out_reg;
  logic [3:0] gin_prev_reg;
  tio_pkg::tio_dbn_t lim_eff [2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_trig
      assign trig_act[gi] = (ext_trig_in[gi] == pol_reg[gi]); // see [R05]
      assign lim_eff[gi] = (dbn_reg[gi] == 8'h00) ? `TIO_DBN_MIN : dbn_reg[gi]; // see [R03]
      tio_debounce u_trig_dbn (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .step(tick_reg),
        .limit(lim_eff[gi]),
        .din(trig_act[gi]),
        .level_o(trig_lvl[gi])
      ); // see [R01] see [R02] see [R13]
      assign trig_rise[gi] = trig_lvl[gi] & ~trig_prev_reg[gi]; // see [R04]
      tio_debounce u_enc_dbn (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .step(1'b1),
        .limit(8'(`TIO_ENC_CYC - 1)),
        .din(enc_raw[gi]),
        .level_o(enc_lvl[gi])
      ); // see [R09]
    end
  endgenerate

  assign enc_raw = {enc_phase_b, enc_phase_a}; // see [R08]

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trig_prev_reg <= 2'h0;
      enc_out_reg <= 2'h0;
      gin_prev_reg <= 4'h0;
    end else begin
      trig_prev_reg <= trig_lvl;
      enc_out_reg <= enc_lvl; // see [R08]
      gin_prev_reg <= gen_in;
    end
  end

  // register access and interrupts
  always_comb begin
    pol_next = pol_reg;
    ten_next = ten_reg;
    two_next = two_reg;
    soft_next = 1'b0;
    dbn_next = dbn_reg;
    gpo_next = gpo_reg;
    stb_en_next = stb_en_reg;
    stb_lvl_next = stb_lvl_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `TIO_OFF_CTRL: begin
          pol_next = reg_wdata[`TIO_CTRL_POL +: 2];
          ten_next = reg_wdata[`TIO_CTRL_EN +: 2];
          two_next = reg_wdata[`TIO_CTRL_TWO];
          soft_next = reg_wdata[`TIO_CTRL_SOFT]; // see [R06]
        end
        `TIO_OFF_DBN: begin
          dbn_next[0] = reg_wdata[`TIO_DBN_T1 +: 8]; // see [R01]
          dbn_next[1] = reg_wdata[`TIO_DBN_T2 +: 8];
        end
        `TIO_OFF_GPO: begin
          gpo_next = reg_wdata[3:0]; // see [R11]
        end
        `TIO_OFF_STROBE: begin
          stb_en_next = reg_wdata[`TIO_STB_EN +: 2]; // see [R12]
          stb_lvl_next = reg_wdata[`TIO_STB_LVL +: 2];
        end
        `TIO_OFF_ISTAT: begin
          istat_next = istat_reg & ~reg_wdata[5:0];
        end
        `TIO_OFF_IMASK: begin
          imask_next = reg_wdata[5:0];
        end
        default: begin
          istat_next = istat_reg;
        end
      endcase
    end
    // events win over a clear in the same cycle
    istat_next = istat_next | {trig_rise, gen_in ^ gin_prev_reg}; // see [R10]
    if (reg_rd) begin
      case (reg_addr)
        `TIO_OFF_CTRL: rdata_next = {27'h0, two_reg, ten_reg, pol_reg};
        `TIO_OFF_DBN: rdata_next = {16'h0, dbn_reg[1], dbn_reg[0]};
        `TIO_OFF_GPO: rdata_next = {28'h0, gpo_reg};
        `TIO_OFF_STROBE: rdata_next = {28'h0, stb_lvl_reg, stb_en_reg};
        `TIO_OFF_LEVEL: rdata_next = {24'h0, enc_lvl, trig_lvl, gen_in}; // see [R10]
        `TIO_OFF_ISTAT: rdata_next = {26'h0, istat_reg};
        `TIO_OFF_IMASK: rdata_next = {26'h0, imask_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    irq_next = |(istat_reg & imask_reg); // see [R10]
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pol_reg <= `TIO_POL_RST;
      ten_reg <= `TIO_EN_RST;
      two_reg <= 1'b0;
      soft_reg <= 1'b0;
      dbn_reg[0] <= `TIO_DBN_RST;
      dbn_reg[1] <= `TIO_DBN_RST;
      gpo_reg <= `TIO_GPO_RST;
      stb_en_reg <= `TIO_STB_RST;
      stb_lvl_reg <= `TIO_STB_RST;
      istat_reg <= `TIO_INT_RST;
      imask_reg <= `TIO_INT_RST;
      rdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      pol_reg <= pol_next;
      ten_reg <= ten_next;
      two_reg <= two_next;
      soft_reg <= soft_next;
      dbn_reg <= dbn_next;
      gpo_reg <= gpo_next;
      stb_en_reg <= stb_en_next;
      stb_lvl_reg <= stb_lvl_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  // acquisition trigger and two-pulse frame tracking
  tio_pkg::tio_frame_t frame_reg;
  tio_pkg::tio_frame_t frame_next;
  logic acq_reg;
  logic acq_next;
  logic fend_reg;
  logic fend_next;
  logic t1_ok;

  always_comb begin
    frame_next = frame_reg;
    fend_next = 1'b0;
    t1_ok = ten_reg[0] & trig_rise[0];
    if (two_reg) begin
      case (frame_reg)
        tio_pkg::TIO_FR_IDLE: begin
          if (t1_ok) begin
            frame_next = tio_pkg::TIO_FR_OPEN;
          end
        end
        tio_pkg::TIO_FR_OPEN: begin
          t1_ok = 1'b0;
          if (ten_reg[1] & trig_rise[1]) begin // see [R07]
            frame_next = tio_pkg::TIO_FR_IDLE;
            fend_next = 1'b1;
          end
        end
        default: begin
          frame_next = tio_pkg::TIO_FR_IDLE;
        end
      endcase
    end else begin
      frame_next = tio_pkg::TIO_FR_IDLE;
    end
    acq_next = t1_ok | soft_reg; // see [R04] see [R06]
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frame_reg <= tio_pkg::TIO_FR_IDLE;
      acq_reg <= 1'b0;
      fend_reg <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      acq_reg <= acq_next;
      fend_reg <= fend_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign gen_out = gpo_reg;
  assign strobe_out = stb_lvl_reg;
  assign strobe_oe = stb_en_reg;
  assign acq_trig = acq_reg;
  assign frame_end = fend_reg;
  assign line_phase_a = enc_out_reg[0];
  assign line_phase_b = enc_out_reg[1];
  assign irq = irq_reg;

  // assertion helper: consecutive active cycles of trigger input 1
  logic [15:0] act_cyc;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !trig_act[0]) begin
      act_cyc <= 16'h0000;
    end else if (act_cyc != 16'hFFFF) begin
      act_cyc <= act_cyc + 16'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  tick_period_a: assert property (tick_reg |=> !tick_reg [*8]) // see [R13]
    else $error("microsecond tick too frequent");
  trig_width_a: assert property ($rose(trig_lvl[0]) |->
      act_cyc >= 16'(lim_eff[0]) * 16'(`TIO_TICK_CYC)) // see [R02]
    else $error("trigger validated before debounce time");
  zero_dbn_a: assert property ($rose(trig_lvl[0]) && dbn_reg[0] == 8'h00 |->
      act_cyc >= 16'(`TIO_TICK_CYC)) // see [R03]
    else $error("zero debounce not treated as minimum");
  trig_report_a: assert property (trig_rise[0] && ten_reg[0] && !two_reg |=> acq_trig) // see [R04]
    else $error("validated trigger not reported");
  soft_trig_a: assert property (reg_wr && reg_addr == `TIO_OFF_CTRL &&
      reg_wdata[`TIO_CTRL_SOFT] |-> ##2 acq_trig) // see [R06]
    else $error("software trigger lost");
  frame_end_a: assert property (frame_end |-> $past(two_reg) && $past(trig_rise[1])) // see [R07]
    else $error("frame end without second trigger");
  enc_filt_a: assert property ($changed(enc_lvl[0]) |->
      $past(enc_phase_a) == enc_lvl[0] && $past(enc_phase_a, 2) == enc_lvl[0]) // see [R09]
    else $error("encoder glitch passed filter");
  gin_irq_a: assert property (gen_in[0] != gin_prev_reg[0] && imask_reg[0] &&
      !(reg_wr && reg_addr == `TIO_OFF_IMASK) |-> ##2 irq) // see [R10]
    else $error("general input change raised no interrupt");
  gpo_write_a: assert property (reg_wr && reg_addr == `TIO_OFF_GPO |=>
      gen_out == $past(reg_wdata[3:0])) // see [R11]
    else $error("general output not updated");
  strobe_oe_a: assert property (reg_wr && reg_addr == `TIO_OFF_STROBE |=>
      strobe_oe == $past(reg_wdata[1:0])) // see [R12]
    else $error("strobe enable not updated");

  soft_c: cover property (soft_reg ##1 acq_trig);
  ext_trig_c: cover property (trig_rise[0] ##1 acq_trig);
  frame_c: cover property (frame_reg == tio_pkg::TIO_FR_OPEN ##[1:1000] frame_end);
  irq_c: cover property ($rose(irq));
endmodule : tio_top

// ---- verif/tio_far_end.sv ----
// far side model: trigger sources, shaft encoder and general input drivers
`timescale 1ns/10ps
module tio_far_end (
  input wire logic sys_clk,
  output logic [1:0] ext_trig_in,
  output logic enc_phase_a,
  output logic enc_phase_b,
  output logic [3:0] gen_in
);
  initial begin
    ext_trig_in = 2'h0;
    enc_phase_a = 1'b0;
    enc_phase_b = 1'b0;
    gen_in = 4'h0;
  end

  // holds one trigger line at its active level for n cycles, then releases it
  task pulse(input int idx, input logic act, input int n);
    @(posedge sys_clk);
    ext_trig_in[idx] <= act;
    repeat (n) @(posedge sys_clk);
    ext_trig_in[idx] <= ~act;
  endtask : pulse

  // phase a high for n cycles; n of 1 is a glitch
  task enc_a(input int n);
    @(posedge sys_clk);
    enc_phase_a <= 1'b1;
    repeat (n) @(posedge sys_clk);
    enc_phase_a <= 1'b0;
  endtask : enc_a

  task set_b(input logic v);
    @(posedge sys_clk);
    enc_phase_b <= v;
  endtask : set_b

  task set_gin(input logic [3:0] v);
    @(posedge sys_clk);
    gen_in <= v;
  endtask : set_gin
endmodule : tio_far_end

// ---- verif/tio_top_tb.sv ----
// self-checking bench for the trigger and i/o conditioning block
`timescale 1ns/10ps
`include "tio_params.svh"
module tio_top_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] ext_trig_in;
  logic enc_phase_a;
  logic enc_phase_b;
  logic [3:0] gen_in;
  logic [3:0] gen_out;
  logic [1:0] strobe_out;
  logic [1:0] strobe_oe;
  logic acq_trig;
  logic frame_end;
  logic line_phase_a;
  logic line_phase_b;
  logic irq;
  int miscompares = 0;
  int comparisons = 0;
  int acq_cnt = 0;
  int fe_cnt = 0;
  int la_cnt = 0;
  logic la_prev = 1'b0;
  int base;
  logic [31:0] d;

  always #25 sys_clk = ~sys_clk;

  tio_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_trig_in(ext_trig_in), .enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b),
    .gen_in(gen_in), .gen_out(gen_out), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
    .acq_trig(acq_trig), .frame_end(frame_end), .line_phase_a(line_phase_a),
    .line_phase_b(line_phase_b), .irq(irq));

  tio_far_end far_u (.sys_clk(sys_clk), .ext_trig_in(ext_trig_in),
    .enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b), .gen_in(gen_in));

  // pulse counters: acq_trig and frame_end stand one cycle, line_phase_a counted on rising edges
  always @(posedge sys_clk) begin
    if (acq_trig === 1'b1) acq_cnt++;
    if (frame_end === 1'b1) fe_cnt++;
    if (line_phase_a === 1'b1 && la_prev === 1'b0) la_cnt++;
    la_prev <= line_phase_a;
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`TIO_OFF_CTRL, d);
    chk("ctrl reset", d, 32'h3);
    rd(8'h1C, d);
    chk("unmapped", d, 32'h0);
    chk("strobe oe reset", {30'h0, strobe_oe}, 32'h0);
    wr(`TIO_OFF_GPO, 32'h5);
    @(negedge sys_clk);
    chk("gen_out", {28'h0, gen_out}, 32'h5);
    wr(`TIO_OFF_STROBE, 32'hD);
    @(negedge sys_clk);
    chk("strobe", {28'h0, strobe_out, strobe_oe}, 32'hD);
    base = acq_cnt;
    wr(`TIO_OFF_CTRL, 32'h103);
    @(posedge sys_clk);
    #1 chk("soft trig", {31'h0, acq_trig}, 32'h1);
    wr(`TIO_OFF_CTRL, 32'h7);
    far_u.pulse(0, 1'b1, 15);
    repeat (60) @(posedge sys_clk);
    chk("short pulse", acq_cnt, base + 1);
    far_u.pulse(0, 1'b1, 45);
    repeat (60) @(posedge sys_clk);
    chk("dbn zero pulse", acq_cnt, base + 2);
    wr(`TIO_OFF_DBN, 32'h3);
    rd(`TIO_OFF_DBN, d);
    chk("dbn readback", d, 32'h3);
    far_u.pulse(0, 1'b1, 55);
    repeat (100) @(posedge sys_clk);
    chk("dbn3 short", acq_cnt, base + 2);
    far_u.pulse(0, 1'b1, 85);
    repeat (100) @(posedge sys_clk);
    chk("dbn3 long", acq_cnt, base + 3);
    wr(`TIO_OFF_ISTAT, 32'h3F);
    wr(`TIO_OFF_CTRL, 32'h2);
    far_u.pulse(0, 1'b0, 85);
    repeat (100) @(posedge sys_clk);
    chk("disabled trig", acq_cnt, base + 3);
    rd(`TIO_OFF_ISTAT, d);
    chk("istat disabled", d, 32'h10);
    wr(`TIO_OFF_ISTAT, 32'h3F);
    wr(`TIO_OFF_CTRL, 32'h6);
    far_u.pulse(0, 1'b0, 85);
    repeat (100) @(posedge sys_clk);
    chk("active low", acq_cnt, base + 4);
    rd(`TIO_OFF_ISTAT, d);
    chk("istat trig", d, 32'h10);
    wr(`TIO_OFF_ISTAT, 32'h10);
    rd(`TIO_OFF_ISTAT, d);
    chk("istat clear", d, 32'h0);
    wr(`TIO_OFF_CTRL, 32'h1E);
    far_u.pulse(1, 1'b1, 45);
    repeat (100) @(posedge sys_clk);
    chk("stray end", fe_cnt, 0);
    far_u.pulse(0, 1'b0, 85);
    repeat (100) @(posedge sys_clk);
    far_u.pulse(1, 1'b1, 45);
    repeat (100) @(posedge sys_clk);
    chk("frame open", acq_cnt, base + 5);
    chk("frame end", fe_cnt, 1);
    far_u.enc_a(1);
    repeat (5) @(posedge sys_clk);
    chk("enc glitch", la_cnt, 0);
    far_u.enc_a(4);
    repeat (5) @(posedge sys_clk);
    chk("enc pulse", la_cnt, 1);
    far_u.set_b(1'b1);
    repeat (5) @(posedge sys_clk);
    rd(`TIO_OFF_LEVEL, d);
    chk("enc level", d & 32'hC0, 32'h80);
    chk("line b", {31'h0, line_phase_b}, 32'h1);
    wr(`TIO_OFF_ISTAT, 32'h3F);
    wr(`TIO_OFF_IMASK, 32'h1);
    far_u.set_gin(4'h3);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq set", {31'h0, irq}, 32'h1);
    rd(`TIO_OFF_ISTAT, d);
    chk("istat gin", d, 32'h3);
    rd(`TIO_OFF_LEVEL, d);
    chk("gin level", d & 32'hF, 32'h3);
    wr(`TIO_OFF_ISTAT, 32'h1);
    repeat (3) @(posedge sys_clk);
    #1 chk("irq masked", {31'h0, irq}, 32'h0);
    close_out();
  end
endmodule : tio_top_tb
